// *** hdl/mbod_pkg.sv ***
// Purpose: Constants and types for the byte-op instruction decoder
// Assumes: 16-bit program words, one core clock MCLK_I
// Notes: Instruction cycle is four clock periods
package mbod_pkg;
   // Instruction cycle length in clock periods
   localparam int OSC_PER_INSTR = 4;
   localparam logic [1:0] OSC_LAST = 2'(OSC_PER_INSTR - 1);
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_TPTR = 8'h08;
   localparam logic [7:0] REG_TLAT = 8'h0c;
   // Control fields and reset values
   localparam int CTRL_PSA_POS = 0;
   localparam int CTRL_BSR_POS = 8;
   localparam logic [3:0] BSR_RST = 4'h0;
   localparam logic [20:0] TPTR_RST = 21'h000000;
   localparam logic [7:0] TLAT_RST = 8'h00;
   // Instruction word field positions
   localparam int F_D = 9;
   localparam int F_A = 8;
   // Flag mask layout {N,OV,Z,DC,C}
   localparam logic [4:0] FM_NONE = 5'h00;
   localparam logic [4:0] FM_ALL = 5'h1f;
   localparam logic [4:0] FM_ZN = 5'h14;
   localparam logic [4:0] FM_CZN = 5'h15;
   localparam logic [4:0] FM_Z = 5'h04;
   // Destination one-hot layout
   localparam logic [2:0] DS_NONE = 3'h0;
   localparam logic [2:0] DS_W = 3'h1;
   localparam logic [2:0] DS_F = 3'h2;
   localparam logic [2:0] DS_P = 3'h4;
   // Decoded byte operations, index of the one-hot output
   typedef enum logic [4:0] {
      OP_NONE, OP_ADD, OP_ADDC, OP_SUBW, OP_SUBWB, OP_SUBFW, OP_OR, OP_AND,
      OP_XOR, OP_COMP, OP_INC, OP_DEC, OP_DECSKZ, OP_DECSKNZ, OP_INCSKZ,
      OP_INCSKNZ, OP_CMPEQ, OP_CMPGT, OP_CMPLT, OP_TSTZ, OP_ROLC, OP_RORC,
      OP_ROL, OP_ROR, OP_SWAP, OP_CLR, OP_SET, OP_STW, OP_NEG, OP_MOV,
      OP_MUL, OP_F2F
   } mbod_op_t;
   // Sequencer states
   typedef enum logic [1:0] {
      S_RUN = 2'b00, S_WORD2 = 2'b01, S_FLUSH = 2'b10, S_DROP = 2'b11
   } mbod_st_t;
   // Operand fields handed to the datapath
   typedef struct packed {
      logic [11:0] file_addr;
      logic [11:0] dst_addr;
      logic [7:0] bit_sel;
      logic [7:0] literal;
      logic [19:0] offset;
      logic [19:0] target;
      logic fast;
   } mbod_dec_t;
endpackage

// *** hdl/mbod_decoder.sv ***
// Purpose: Decode 16-bit program words into operand fields and controls
// Assumes: Words and condition result are synchronous to MCLK_I
// Notes: Registers reached over classic Wishbone, one-cycle ack
`timescale 1ns/10ps
module mbod_decoder #(
   parameter logic [7:0] ACCESS_SPLIT = 8'h80,
   parameter logic [3:0] ACCESS_HI_BANK = 4'hf,
   parameter logic [11:0] PORT_LO = 12'hf00,
   parameter logic [11:0] PORT_HI = 12'hf0f,
   parameter logic [11:0] TIMER_ZERO_COUNT_ADDR = 12'hf10
) (
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [15:0] INSTR_I,
   input wire logic COND_TRUE_I,
   input wire logic [7:0] TBL_RDATA_I,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic ACK_O,
   output logic [31:0] DAT_O,
   output logic INSTR_CE_O,
   output mbod_pkg::mbod_dec_t DEC_O,
   output logic [31:0] ALU_OH_O,
   output logic [2:0] DEST_OH_O,
   output logic [4:0] FLAG_MASK_O,
   output logic NOP_O,
   output logic OPND_PINS_O,
   output logic PRE_CLR_O,
   output logic SHADOW_SAVE_O,
   output logic SHADOW_LOAD_O,
   output logic TBL_RD_O,
   output logic TBL_WR_O,
   output logic [20:0] TBL_ADDR_O,
   output logic [7:0] TBL_LATCH_O
);
   // Byte-lane merge for register writes
   function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Byte-oriented opcode table, d and a bits masked
   function automatic mbod_pkg::mbod_op_t op_of(input logic [15:0] x);
      casez (x[15:9])
         7'b001001?: op_of = mbod_pkg::OP_ADD;
         7'b001000?: op_of = mbod_pkg::OP_ADDC;
         7'b010111?: op_of = mbod_pkg::OP_SUBW;
         7'b010110?: op_of = mbod_pkg::OP_SUBWB;
         7'b010101?: op_of = mbod_pkg::OP_SUBFW;
         7'b000100?: op_of = mbod_pkg::OP_OR;
         7'b000101?: op_of = mbod_pkg::OP_AND;
         7'b000110?: op_of = mbod_pkg::OP_XOR;
         7'b000111?: op_of = mbod_pkg::OP_COMP;
         7'b001010?: op_of = mbod_pkg::OP_INC;
         7'b000001?: op_of = mbod_pkg::OP_DEC;
         7'b001011?: op_of = mbod_pkg::OP_DECSKZ;
         7'b010011?: op_of = mbod_pkg::OP_DECSKNZ;
         7'b001111?: op_of = mbod_pkg::OP_INCSKZ;
         7'b010010?: op_of = mbod_pkg::OP_INCSKNZ;
         7'b0110001: op_of = mbod_pkg::OP_CMPEQ;
         7'b0110010: op_of = mbod_pkg::OP_CMPGT;
         7'b0110000: op_of = mbod_pkg::OP_CMPLT;
         7'b0110011: op_of = mbod_pkg::OP_TSTZ;
         7'b001101?: op_of = mbod_pkg::OP_ROLC;
         7'b001100?: op_of = mbod_pkg::OP_RORC;
         7'b010001?: op_of = mbod_pkg::OP_ROL;
         7'b010000?: op_of = mbod_pkg::OP_ROR;
         7'b001110?: op_of = mbod_pkg::OP_SWAP;
         7'b0110101: op_of = mbod_pkg::OP_CLR;
         7'b0110100: op_of = mbod_pkg::OP_SET;
         7'b0110111: op_of = mbod_pkg::OP_STW;
         7'b0110110: op_of = mbod_pkg::OP_NEG;
         7'b010100?: op_of = mbod_pkg::OP_MOV;
         7'b0000001: op_of = mbod_pkg::OP_MUL;
         7'b1100???: op_of = mbod_pkg::OP_F2F;
         default: op_of = mbod_pkg::OP_NONE;
      endcase
   endfunction

   // Flag-update mask per operation
   function automatic logic [4:0] flags_of(input mbod_pkg::mbod_op_t op);
      case (op)
         mbod_pkg::OP_ADD, mbod_pkg::OP_ADDC, mbod_pkg::OP_SUBW,
         mbod_pkg::OP_SUBWB, mbod_pkg::OP_SUBFW, mbod_pkg::OP_INC,
         mbod_pkg::OP_DEC, mbod_pkg::OP_NEG: flags_of = mbod_pkg::FM_ALL;
         mbod_pkg::OP_OR, mbod_pkg::OP_AND, mbod_pkg::OP_XOR,
         mbod_pkg::OP_COMP, mbod_pkg::OP_ROL, mbod_pkg::OP_ROR,
         mbod_pkg::OP_MOV: flags_of = mbod_pkg::FM_ZN;
         mbod_pkg::OP_ROLC, mbod_pkg::OP_RORC: flags_of = mbod_pkg::FM_CZN;
         mbod_pkg::OP_CLR: flags_of = mbod_pkg::FM_Z;
         default: flags_of = mbod_pkg::FM_NONE;  // Skips, swap, set, store
      endcase
   endfunction

   // Where the result goes; d bit only for the d forms
   function automatic logic [2:0] dest_of(input mbod_pkg::mbod_op_t op,
                                          input logic d);
      case (op)
         mbod_pkg::OP_NONE, mbod_pkg::OP_CMPEQ, mbod_pkg::OP_CMPGT,
         mbod_pkg::OP_CMPLT, mbod_pkg::OP_TSTZ,
         mbod_pkg::OP_F2F: dest_of = mbod_pkg::DS_NONE;
         mbod_pkg::OP_MUL: dest_of = mbod_pkg::DS_P;
         mbod_pkg::OP_CLR, mbod_pkg::OP_SET, mbod_pkg::OP_STW,
         mbod_pkg::OP_NEG: dest_of = mbod_pkg::DS_F;
         default: dest_of = d ? mbod_pkg::DS_F : mbod_pkg::DS_W;
      endcase
   endfunction

   // First words of the four two-word forms
   function automatic logic two_word(input logic [15:0] x);
      two_word = (x[15:12] == 4'hc) || (x[15:9] == 7'b1110110) ||
                 (x[15:8] == 8'hef) || (x[15:8] == 8'hee);
   endfunction

   // Instruction-cycle divider
   logic [1:0] div_reg;
   logic tick;
   assign tick = (div_reg == mbod_pkg::OSC_LAST);
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // Register-side state
   mbod_pkg::mbod_st_t st_reg, st_next;
   logic [3:0] bsr_reg;          // bank_select_reg
   logic psa_reg;                // Prescaler assigned to timer zero
   logic [20:0] tptr_reg;        // table_pointer
   logic [7:0] tlat_reg;         // table_latch
   logic rd_pend_reg;            // Table read awaiting data
   mbod_pkg::mbod_op_t op_reg;   // Last decoded operation

   // Word classification, valid only in the run state
   logic run;
   logic [15:0] w;
   mbod_pkg::mbod_op_t op_w;
   logic [2:0] dest_w;
   logic is_rel, is_cbr, is_bskip, is_call, is_ret, is_retlw, is_tbl;
   logic is_skip, pc_chg, stray2;
   assign run = (st_reg == mbod_pkg::S_RUN);
   assign w = INSTR_I;
   assign op_w = run ? op_of(w) : mbod_pkg::OP_NONE;
   assign dest_w = dest_of(op_w, w[mbod_pkg::F_D]);
   assign is_rel = (w[15:12] == 4'hd);                   // Jump, relative call
   assign is_cbr = (w[15:11] == 5'b11100);               // Conditional branch
   assign is_bskip = (w[15:13] == 3'b101);               // Bit test skips
   assign is_call = (w[15:9] == 7'b1110110);
   assign is_ret = (w[15:2] == 14'h0004);                // Return forms
   assign is_retlw = (w[15:8] == 8'h0c);
   assign is_tbl = (w[15:4] == 12'h000) && w[3];
   assign stray2 = (w[15:12] == 4'hf);
   assign is_skip = (op_w >= mbod_pkg::OP_DECSKZ) && (op_w <= mbod_pkg::OP_TSTZ);
   // Taken conditions, unconditional flow changes, or table operations
   assign pc_chg = is_rel || is_ret || is_retlw || is_tbl ||
                   (is_cbr && COND_TRUE_I);

   // Sequencer: two-word capture and discard cycles
   always_comb begin
      st_next = st_reg;
      if (tick) begin
         case (st_reg)
            mbod_pkg::S_RUN: begin
               if (two_word(w)) begin
                  st_next = mbod_pkg::S_WORD2;
               end else if ((is_skip || is_bskip) && COND_TRUE_I) begin
                  st_next = mbod_pkg::S_FLUSH;
               end else if (pc_chg) begin
                  st_next = mbod_pkg::S_DROP;
               end else begin
                  st_next = mbod_pkg::S_RUN;
               end
            end
            mbod_pkg::S_WORD2: st_next = mbod_pkg::S_RUN;
            // A skipped two-word form costs one more cycle
            mbod_pkg::S_FLUSH: begin
               st_next = two_word(w) ? mbod_pkg::S_DROP : mbod_pkg::S_RUN;
            end
            mbod_pkg::S_DROP: st_next = mbod_pkg::S_RUN;
            default: st_next = mbod_pkg::S_RUN;
         endcase
      end
   end

   // Operand fields; second word only fills the upper target or dest
   mbod_pkg::mbod_dec_t dec_reg, dec_next;
   logic [11:0] fa_w;
   assign fa_w = w[mbod_pkg::F_A] ? {bsr_reg, w[7:0]} :
                 (w[7:0] < ACCESS_SPLIT) ? {4'h0, w[7:0]} :
                 {ACCESS_HI_BANK, w[7:0]};
   always_comb begin
      dec_next = dec_reg;
      if (tick && run) begin
         // Byte ops and moves carry their file address low
         dec_next.file_addr = (op_w == mbod_pkg::OP_F2F) ? w[11:0] : fa_w;
         dec_next.bit_sel = 8'h01 << w[11:9];
         dec_next.literal = w[7:0];
         dec_next.offset = is_rel ? {{9{w[10]}}, w[10:0]} :
                                   {{12{w[7]}}, w[7:0]};
         dec_next.target = {12'h000, w[7:0]};
         dec_next.fast = is_call ? w[8] : w[0];
      end else if (tick && (st_reg == mbod_pkg::S_WORD2)) begin
         dec_next.dst_addr = w[11:0];
         dec_next.target = {w[11:0], dec_reg.target[7:0]};
      end
   end

   // Side effects of the decoded word
   logic pins_w, pre_clr_w;
   assign pins_w = run && (op_w != mbod_pkg::OP_NONE) && (op_w != mbod_pkg::OP_STW) &&
                   (op_w != mbod_pkg::OP_CLR) && (op_w != mbod_pkg::OP_SET) &&
                   (fa_w >= PORT_LO) && (fa_w <= PORT_HI);
   assign pre_clr_w = tick && psa_reg && (fa_w == TIMER_ZERO_COUNT_ADDR) &&
                      (dest_w == mbod_pkg::DS_F);

   // Wishbone decode
   logic wb_go, wr_go;
   logic [31:0] rd_mux;
   assign wb_go = CYC_I && STB_I && !ACK_O;
   assign wr_go = wb_go && WE_I;
   assign rd_mux = (ADR_I == mbod_pkg::REG_CTRL) ?
                   {20'h00000, bsr_reg, 7'h00, psa_reg} :
                   (ADR_I == mbod_pkg::REG_STAT) ? {19'h00000, op_reg, 6'h00, st_reg} :
                   (ADR_I == mbod_pkg::REG_TPTR) ? {11'h000, tptr_reg} :
                   (ADR_I == mbod_pkg::REG_TLAT) ? {24'h000000, tlat_reg} :
                   32'h00000000;                            // Unmapped reads zero
   logic [31:0] ctrl_wr, tptr_wr, tlat_wr;
   assign ctrl_wr = wb_merge({20'h00000, bsr_reg, 7'h00, psa_reg}, DAT_I, SEL_I);
   assign tptr_wr = wb_merge({11'h000, tptr_reg}, DAT_I, SEL_I);
   assign tlat_wr = wb_merge({24'h000000, tlat_reg}, DAT_I, SEL_I);

   // Table pointer step per encoded mode
   logic [20:0] tptr_step;
   assign tptr_step = (w[1:0] == 2'b10) ? tptr_reg - 21'h000001 :
                      (w[1:0] == 2'b00) ? tptr_reg : tptr_reg + 21'h000001;

   // Sequencer and decode registers; reset drops any half word
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         st_reg <= mbod_pkg::S_RUN;
         dec_reg <= '0;
         op_reg <= mbod_pkg::OP_NONE;
      end else begin
         st_reg <= st_next;
         dec_reg <= dec_next;
         if (tick) begin
            op_reg <= op_w;
         end
      end
   end

   // Control outputs, updated once per instruction cycle
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         ALU_OH_O <= 32'h00000001;
         DEST_OH_O <= mbod_pkg::DS_NONE;
         FLAG_MASK_O <= mbod_pkg::FM_NONE;
         NOP_O <= 1'b1;
         OPND_PINS_O <= 1'b0;
      end else if (tick) begin
         ALU_OH_O <= 32'h00000001 << op_w;
         DEST_OH_O <= dest_w;
         FLAG_MASK_O <= flags_of(op_w);
         NOP_O <= !run || stray2;
         OPND_PINS_O <= pins_w;
      end
   end

   // One-cycle strobes following the instruction edge
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PRE_CLR_O <= 1'b0;
         SHADOW_SAVE_O <= 1'b0;
         SHADOW_LOAD_O <= 1'b0;
         TBL_RD_O <= 1'b0;
         TBL_WR_O <= 1'b0;
      end else begin
         PRE_CLR_O <= pre_clr_w && run;
         SHADOW_SAVE_O <= tick && run && is_call && w[8];
         SHADOW_LOAD_O <= tick && run && is_ret && w[0];
         TBL_RD_O <= tick && run && is_tbl && !w[2];
         TBL_WR_O <= tick && run && is_tbl && w[2];
      end
   end

   // Table pointer and latch; table instruction wins a collision with a software write
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         tptr_reg <= mbod_pkg::TPTR_RST;
         tlat_reg <= mbod_pkg::TLAT_RST;
         rd_pend_reg <= 1'b0;
         TBL_ADDR_O <= mbod_pkg::TPTR_RST;
      end else begin
         if (tick && run && is_tbl) begin
            tptr_reg <= tptr_step;
            TBL_ADDR_O <= (w[1:0] == 2'b11) ? tptr_step : tptr_reg;
         end else if (wr_go && ADR_I == mbod_pkg::REG_TPTR) begin
            tptr_reg <= tptr_wr[20:0];
         end
         // Read data is taken one instruction cycle later
         if (tick) begin
            rd_pend_reg <= run && is_tbl && !w[2];
         end
         if (tick && rd_pend_reg) begin
            tlat_reg <= TBL_RDATA_I;
         end else if (wr_go && ADR_I == mbod_pkg::REG_TLAT) begin
            tlat_reg <= tlat_wr[7:0];
         end
      end
   end

   // Wishbone slave: control register and answer
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         bsr_reg <= mbod_pkg::BSR_RST;
         psa_reg <= 1'b0;
         ACK_O <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ACK_O <= wb_go;
         if (wb_go && !WE_I) begin
            DAT_O <= rd_mux;
         end
         if (wr_go && ADR_I == mbod_pkg::REG_CTRL) begin
            bsr_reg <= ctrl_wr[mbod_pkg::CTRL_BSR_POS +: 4];
            psa_reg <= ctrl_wr[mbod_pkg::CTRL_PSA_POS];
         end
      end
   end

   assign INSTR_CE_O = tick;
   assign DEC_O = dec_reg;
   assign TBL_LATCH_O = tlat_reg;

   // Checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_tick;
      tick |=> !tick [*3] ##1 tick;
   endproperty
   a_tick: assert property (p_tick) else $error("cycle not four clocks");

   property p_bank;
      tick && run && w[8] && w[15:12] != 4'hc |=>
         DEC_O.file_addr[11:8] == $past(bsr_reg);
   endproperty
   a_bank: assert property (p_bank) else $error("bank not from select");

   property p_bit;
      $onehot(DEC_O.bit_sel) || DEC_O.bit_sel == 8'h00;
   endproperty
   a_bit: assert property (p_bit) else $error("bit select not one-hot");

   property p_oh;
      $onehot(ALU_OH_O) && $onehot0(DEST_OH_O);
   endproperty
   a_oh: assert property (p_oh) else $error("control not one-hot");

   property p_stray;
      tick && run && w[15:12] == 4'hf |=> NOP_O;
   endproperty
   a_stray: assert property (p_stray) else $error("stray word not no-op");

   property p_skip;
      tick && run && is_skip && COND_TRUE_I |=> ##3 tick ##1 NOP_O;
   endproperty
   a_skip: assert property (p_skip) else $error("taken skip not flushed");

   property p_pre;
      PRE_CLR_O |-> psa_reg && $past(tick);
   endproperty
   a_pre: assert property (p_pre) else $error("prescaler clear unowned");

   property p_shadow;
      SHADOW_SAVE_O |-> DEC_O.fast && !SHADOW_LOAD_O;
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow save without fast");

   property p_tbl;
      tick && run && w == 16'h0009 |=> tptr_reg == $past(tptr_reg) + 21'h000001;
   endproperty
   a_tbl: assert property (p_tbl) else $error("post-increment missed");

   property p_ack;
      ACK_O |=> !ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule

// *** testbench/mbod_prog_mem.sv ***
// Purpose: Program memory model feeding one word per tick
// Assumes: Bench loads the image before go_i rises
// Notes: Word holds between ticks, like a fetch latch
`timescale 1ns/10ps
module mbod_prog_mem (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic go_i,
   output logic [15:0] word_o
);
   logic [15:0] mem [0:63]; // Program image
   logic [5:0] ptr_reg; // Fetch pointer
   // Step once per tick, so skipped words are still fetched
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) ptr_reg <= 6'h00;
      else if (tick_i && go_i) ptr_reg <= ptr_reg + 6'h01;
   end
   // Idle fetch shows a plain no-op word
   assign word_o = go_i ? mem[ptr_reg] : 16'h0000;
endmodule

// *** testbench/test_mbod_decoder.sv ***
// Purpose: Self-checking bench for the byte-op decoder
// Assumes: Memory model feeds words, bench drives cond and bus
// Notes: Expected values come from an encoding table
`timescale 1ns/10ps
module test_mbod_decoder;
   logic mclk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, cond = 1'b0, go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h0, dat_r, alu;
   logic [3:0] sel = 4'h0;
   logic [15:0] word;
   logic ack, ce, nop;
   logic sv, trd; // Shadow save and table read strobes
   logic [7:0] tbl_d = 8'h00, tlat; // Table read byte and latch seen
   logic [20:0] taddr; // Effective table address seen
   logic [2:0] dest;
   logic [4:0] fm;
   mbod_pkg::mbod_dec_t dec;
   int seed = 32'hf920, bad_count = 0, total_checks = 0;
   // Per op: {code7, has d, flag mask, fixed dest}, indexed by op value
   logic [15:0] tab [1:30] = '{16'h25f8, 16'h21f8, 16'h5df8, 16'h59f8, 16'h55f8, 16'h11a0,
      16'h15a0, 16'h19a0, 16'h1da0, 16'h29f8, 16'h05f8, 16'h2d00, 16'h4d00, 16'h3d00,
      16'h4900, 16'h6200, 16'h6400, 16'h6000, 16'h6600, 16'h35a8, 16'h31a8, 16'h45a0,
      16'h41a0, 16'h3900, 16'h6a22, 16'h6802, 16'h6e02, 16'h6cfa, 16'h51a0, 16'h0204};
   always #4 mclk = ~mclk;
   mbod_decoder mbod_decoder_i (.MCLK_I(mclk), .RST_N_I(rst_n), .INSTR_I(word),
      .COND_TRUE_I(cond), .TBL_RDATA_I(tbl_d), .ADR_I(adr), .DAT_I(dat_w), .WE_I(we),
      .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .DAT_O(dat_r), .INSTR_CE_O(ce),
      .DEC_O(dec), .ALU_OH_O(alu), .DEST_OH_O(dest), .FLAG_MASK_O(fm), .NOP_O(nop),
      .OPND_PINS_O(), .PRE_CLR_O(), .SHADOW_SAVE_O(sv), .SHADOW_LOAD_O(), .TBL_RD_O(trd),
      .TBL_WR_O(), .TBL_ADDR_O(taddr), .TBL_LATCH_O(tlat));
   mbod_prog_mem mbod_prog_mem_i (.clk_i(mclk), .rst_n_i(rst_n), .tick_i(ce), .go_i(go),
      .word_o(word));
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Compare one value, report at once
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dw,
                     output logic [31:0] dr);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat_w <= dw; sel <= 4'hf;
      do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin bad_count++; close_out(); end
      dr = dat_r;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge mclk);
   endtask
   // Wait, bounded, for the next tick edge
   task automatic tick();
      int n;
      n = 0;
      do begin @(negedge mclk); n++; end while (ce !== 1'b1 && n < 20);
      if (n >= 20) begin bad_count++; close_out(); end
      @(posedge mclk);
   endtask
   initial begin
      logic [15:0] w, e;
      logic [11:0] fa;
      logic [3:0] bank;
      logic [31:0] rd;
      int idx;
      bank = 4'($random(seed));
      // Byte ops with random d, a and file address, then special words
      for (int i = 1; i <= 30; i++) begin
         w = 16'($random(seed));
         mbod_prog_mem_i.mem[i-1] = {tab[i][15:9] | {6'h00, tab[i][8] & w[9]}, w[8:0]};
      end
      mbod_prog_mem_i.mem[30] = {4'hc, 12'($random(seed))};
      mbod_prog_mem_i.mem[31] = {4'hf, 12'($random(seed))};
      mbod_prog_mem_i.mem[32] = 16'hf123;
      mbod_prog_mem_i.mem[33] = 16'h2c10;
      mbod_prog_mem_i.mem[34] = 16'h2603;
      mbod_prog_mem_i.mem[35] = {8'hed, 8'($random(seed))};
      mbod_prog_mem_i.mem[36] = {4'hf, 12'($random(seed))};
      // Table read with post-increment, then the word it drops
      mbod_prog_mem_i.mem[37] = 16'h0009;
      mbod_prog_mem_i.mem[38] = 16'h0000;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      tbl_d <= 8'($random(seed));
      // Bank select, pointer and an unmapped place over the bus
      wb(1'b1, 8'h00, {20'h0, bank, 8'h00}, rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      chk("ctrl bank", {28'h0, bank}, {28'h0, rd[11:8]});
      wb(1'b1, 8'h08, 32'h0015a5c3, rd);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk("tptr", 32'h0015a5c3, rd & 32'h001fffff);
      wb(1'b0, 8'hfc, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      tick();
      go <= 1'b1;
      for (int k = 0; k <= 38; k++) begin
         tick();
         cond <= (k == 32); // Only the skip word sees a true test
         @(negedge mclk);
         w = mbod_prog_mem_i.mem[k];
         idx = (k < 30) ? k + 1 : ((k == 33) ? 12 : 0);
         if (idx != 0) begin
            e = tab[idx];
            fa = w[8] ? {bank, w[7:0]} : {(w[7:0] >= 8'h80) ? 4'hf : 4'h0, w[7:0]};
            chk("alu", 32'h1 << idx, alu);
            chk("flags", {27'h0, e[7:3]}, {27'h0, fm});
            chk("dest", {29'h0, e[8] ? (w[9] ? 3'h2 : 3'h1) : e[2:0]}, {29'h0, dest});
            chk("faddr", {20'h0, fa}, {20'h0, dec.file_addr});
            chk("nop", 32'h0, {31'h0, nop});
         end
         if (k == 30) chk("f2f src", {20'h0, w[11:0]}, {20'h0, dec.file_addr});
         if (k == 31) chk("f2f dst", {20'h0, w[11:0]}, {20'h0, dec.dst_addr});
         if (k == 32) chk("stray", 32'h1, {31'h0, nop});
         if (k == 34) chk("skipped", 32'h1, {31'h0, nop});
         if (k == 36) begin
            e = mbod_prog_mem_i.mem[35];
            chk("target", {12'h0, w[11:0], e[7:0]}, {12'h0, dec.target});
            chk("fast", {31'h0, e[8]}, {31'h0, dec.fast});
         end
         if (k == 35) chk("shadow save", 32'h1, {31'h0, sv});
         if (k == 37) begin
            chk("tbl rd", 32'h1, {31'h0, trd});
            chk("tbl addr", 32'h0015a5c3, {11'h0, taddr});
         end
         if (k == 38) begin
            chk("tbl latch", {24'h0, tbl_d}, {24'h0, tlat});
            chk("tbl dropped", 32'h1, {31'h0, nop});
         end
      end
      // Pointer after one post-increment
      wb(1'b0, 8'h08, 32'h0, rd);
      chk("tptr step", 32'h0015a5c4, rd & 32'h001fffff);
      close_out();
   end
endmodule
